/* verilog/converter_cal_mode_sync_ctrl.sv */
// Purpose: mode select, self-trim sequencing and reference clock distribution
// Assumes: pins are asynchronous to ref_clk; ctrl bits come from a config store
// Notes: cfg_* inputs model the serial-port register writes; the held bits reset to defaults
//        whenever extended control is disabled
`include "cal_sync_consts.svh"

module converter_cal_mode_sync_ctrl
  import cal_sync_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic extended_control_enable_n,
  input wire logic dual_edge_select_pin,
  input wire logic power_on_trim_wait_select,
  input wire logic trim_trigger_pin,
  input wire logic ref_clk_in,
  input wire logic sync_active,
  input wire logic sync_slave,
  input wire logic [`DLY_W-1:0] ref_in_delay,
  input wire logic cfg_write,
  input wire logic [3:0] cfg_addr,
  input wire logic [15:0] cfg_wdata,
  output logic extended_control_mode,
  output logic dual_edge_mode,
  output logic q_input_used,
  output logic sample_both_edges,
  output logic self_trim_active,
  output logic sync_ref_clock_out_a,
  output logic sync_ref_clock_out_b,
  output logic [1:0] divided_phase
);
  import cal_sync_pkg::*;

  // two-stage synchronisers for every pin input
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [4:0] pin_raw;
  assign pin_raw = {ref_clk_in, trim_trigger_pin, power_on_trim_wait_select,
                    dual_edge_select_pin, extended_control_enable_n};
  // no reset on the chain: it keeps tracking the pins while rst is high, so the
  // trigger level seen on the first clock after reset is the real strap level;
  // a reset value here would hide a trigger held high through reset
  always_ff @(posedge ref_clk) begin
    pin_s1_q <= pin_raw;
    pin_s2_q <= pin_s1_q;
  end
  logic ece_n_s;
  logic des_pin_s;
  logic wait_sel_s;
  logic trig_pin_s;
  logic rclk_s;
  assign ece_n_s = pin_s2_q[0];
  assign des_pin_s = pin_s2_q[1];
  assign wait_sel_s = pin_s2_q[2];
  assign trig_pin_s = pin_s2_q[3];
  assign rclk_s = pin_s2_q[4];

  // control bits held while extended control is on
  logic des_bit_q;
  logic des_bit_d;
  logic trim_bit_q;
  logic trim_bit_d;
  logic ref_en_q;
  logic ref_en_d;
  logic ecm_q;
  logic ecm_d;
  always_comb begin
    ecm_d = ~ece_n_s;
    des_bit_d = des_bit_q;
    trim_bit_d = trim_bit_q;
    ref_en_d = ref_en_q;
    if (!ecm_q) begin
      des_bit_d = 1'b0;
      trim_bit_d = 1'b0;
      ref_en_d = 1'b0;
    end else if (cfg_write && cfg_addr == `CTRL_ADDR_MAIN) begin
      des_bit_d = cfg_wdata[`BIT_DES_SELECT];
      trim_bit_d = cfg_wdata[`BIT_TRIM_REQ];
    end else if (cfg_write && cfg_addr == `CTRL_ADDR_SYNC) begin
      ref_en_d = cfg_wdata[`BIT_REF_OUT_EN];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ecm_q <= 1'b0;
      des_bit_q <= 1'b0;
      trim_bit_q <= 1'b0;
      ref_en_q <= 1'b0;
    end else begin
      ecm_q <= ecm_d;
      des_bit_q <= des_bit_d;
      trim_bit_q <= trim_bit_d;
      ref_en_q <= ref_en_d;
    end
  end

  // mode select
  logic des_q;
  logic des_d;
  always_comb begin
    if (ecm_q) begin
      des_d = des_bit_q;
    end else begin
      des_d = des_pin_s;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      des_q <= 1'b0;
    end else begin
      des_q <= des_d;
    end
  end
  assign extended_control_mode = ecm_q;
  assign dual_edge_mode = des_q;
  assign q_input_used = ~des_q;
  assign sample_both_edges = des_q;

  // trigger: pin ORed with bit in extended control, qualified by min low/high times
  logic trig;
  assign trig = trig_pin_s | (ecm_q & trim_bit_q);
  arm_state_type arm_q;
  arm_state_type arm_d;
  logic [`CNT_W-1:0] arm_cnt_q;
  logic [`CNT_W-1:0] arm_cnt_d;
  logic trig_fire;
  always_comb begin
    arm_d = arm_q;
    arm_cnt_d = arm_cnt_q;
    trig_fire = 1'b0;
    unique case (arm_q)
      arm_wait_low: begin
        arm_cnt_d = '0;
        if (!trig) begin
          arm_d = arm_low;
        end
      end
      arm_low: begin
        if (trig) begin
          arm_cnt_d = '0;
          if (arm_cnt_q >= `CNT_W'(`CAL_L_CYCLES)) begin
            arm_d = arm_high;
          end
        end else if (arm_cnt_q < `CNT_W'(`CAL_L_CYCLES)) begin
          arm_cnt_d = arm_cnt_q + `CNT_W'(1);
        end
      end
      arm_high: begin
        if (!trig) begin
          arm_d = arm_low;
          arm_cnt_d = `CNT_W'(1);
        end else if (arm_cnt_q + `CNT_W'(1) >= `CNT_W'(`CAL_H_CYCLES)) begin
          trig_fire = 1'b1;
          arm_d = arm_wait_low;
        end else begin
          arm_cnt_d = arm_cnt_q + `CNT_W'(1);
        end
      end
      default: begin
        arm_d = arm_wait_low;
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arm_q <= arm_wait_low;
      arm_cnt_q <= '0;
    end else begin
      arm_q <= arm_d;
      arm_cnt_q <= arm_cnt_d;
    end
  end

  // trim sequencer; power-on wait is inhibited if the trigger is high on the first clock after reset, until a qualified trigger fires
  trim_state_type trim_q;
  trim_state_type trim_d;
  logic [`CNT_W-1:0] trim_cnt_q;
  logic [`CNT_W-1:0] trim_cnt_d;
  logic por_hold_q;
  logic por_hold_d;
  logic first_q;
  logic first_d;
  logic [`CNT_W-1:0] por_wait;
  assign por_wait = wait_sel_s ? `POR_WAIT_LONG : `POR_WAIT_SHORT;
  always_comb begin
    trim_d = trim_q;
    trim_cnt_d = trim_cnt_q;
    first_d = 1'b0;
    por_hold_d = por_hold_q;
    // strap of trigger level is caught on the first clock after reset
    if (first_q) begin
      por_hold_d = trig;
    end else if (trig_fire) begin
      por_hold_d = 1'b0;
    end
    unique case (trim_q)
      trim_por_wait: begin
        if (trig_fire) begin
          trim_d = trim_run;
          trim_cnt_d = '0;
        end else if (!first_q && !por_hold_q) begin
          if (trim_cnt_q >= por_wait) begin
            trim_d = trim_run;
            trim_cnt_d = '0;
          end else begin
            trim_cnt_d = trim_cnt_q + `CNT_W'(1);
          end
        end
      end
      trim_idle: begin
        trim_cnt_d = '0;
        if (trig_fire) begin
          trim_d = trim_run;
        end
      end
      trim_run: begin
        if (trim_cnt_q >= `TRIM_RUN_CYCLES - `CNT_W'(1)) begin
          trim_d = trim_idle;
          trim_cnt_d = '0;
        end else begin
          trim_cnt_d = trim_cnt_q + `CNT_W'(1);
        end
      end
      default: begin
        trim_d = trim_idle;
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trim_q <= trim_por_wait;
      trim_cnt_q <= '0;
      por_hold_q <= 1'b1;
      first_q <= 1'b1;
    end else begin
      trim_q <= trim_d;
      trim_cnt_q <= trim_cnt_d;
      por_hold_q <= por_hold_d;
      first_q <= first_d;
    end
  end
  assign self_trim_active = (trim_q == trim_run);

  // slave alignment: delay the synchronised reference, align on its rising edge
  logic [(1 << `DLY_W)-1:0] rclk_dly_q;
  logic [(1 << `DLY_W)-1:0] rclk_dly_d;
  logic rclk_prev_q;
  logic rclk_prev_d;
  logic rclk_tap;
  ref_clk_if div_bus ();
  assign rclk_tap = rclk_dly_q[ref_in_delay];
  always_comb begin
    rclk_dly_d = {rclk_dly_q[(1 << `DLY_W)-2:0], rclk_s};
    rclk_prev_d = rclk_tap;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rclk_dly_q <= '0;
      rclk_prev_q <= 1'b0;
    end else begin
      rclk_dly_q <= rclk_dly_d;
      rclk_prev_q <= rclk_prev_d;
    end
  end
  // only the slave re-phases; a master keeps free-running division
  assign div_bus.align_pulse = sync_active & sync_slave & rclk_tap & ~rclk_prev_q;
  ref_divider u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus(div_bus)
  );

  // reference outputs registered, gated by enable, in master and slave alike
  logic ref_out_q;
  logic ref_out_d;
  assign ref_out_d = ref_en_q & div_bus.div_clk;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ref_out_q <= 1'b0;
    end else begin
      ref_out_q <= ref_out_d;
    end
  end
  assign sync_ref_clock_out_a = ref_out_q;
  assign sync_ref_clock_out_b = ref_out_q;
  assign divided_phase = div_bus.phase;
endmodule

/* verilog/cal_sync_consts.svh */
// Purpose: named constants for the calibration, mode select and reference clock block
// Assumes: ref_clk at 125 MHz
// Notes: times are in ns; CAL_L_CYCLES and CAL_H_CYCLES derive from them
`ifndef CAL_SYNC_CONSTS_SVH
`define CAL_SYNC_CONSTS_SVH
`define CLK_PERIOD_NS 8
`define REF_DIV_RATIO 4
`define CTRL_ADDR_MAIN 4'h0
`define CTRL_ADDR_SYNC 4'he
`define BIT_DES_SELECT 7
`define BIT_REF_OUT_EN 1
`define BIT_TRIM_REQ 0
`define T_CAL_L_NS 80
`define T_CAL_H_NS 80
`define CAL_L_CYCLES ((`T_CAL_L_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_H_CYCLES ((`T_CAL_H_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_WAIT_SHORT 16'h0100
`define POR_WAIT_LONG 16'h1000
`define TRIM_RUN_CYCLES 16'h0400
`define CNT_W 16
`define DLY_W 4
`endif

/* verilog/cal_sync_pkg.sv */
// Purpose: shared types for the calibration and sync block
// Assumes: nothing beyond the constants header
// Notes: states encoded in binary
package cal_sync_pkg;
  typedef enum logic [1:0] {
    trim_por_wait = 2'b00,
    trim_idle = 2'b01,
    trim_run = 2'b10
  } trim_state_type;
  typedef enum logic [1:0] {
    arm_wait_low = 2'b00,
    arm_low = 2'b01,
    arm_high = 2'b10
  } arm_state_type;
endpackage

/* verilog/ref_clk_if.sv */
// Purpose: carries the divided clock phase between divider and control
// Assumes: single clock domain
// Notes: phase is the internal divided clock position
interface ref_clk_if;
  logic [1:0] phase;
  logic div_clk;
  logic align_pulse;
  modport divider(output phase, output div_clk, input align_pulse);
  modport ctrl(input phase, input div_clk, output align_pulse);
endinterface

/* verilog/ref_divider.sv */
// Purpose: divide-by-four phase counter with slave alignment
// Assumes: align_pulse is already synchronised
// Notes: alignment loads a fixed phase so all devices agree
module ref_divider (
  input wire logic ref_clk,
  input wire logic rst,
  ref_clk_if.divider bus
);
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  always_comb begin
    if (bus.align_pulse) begin
      phase_d = 2'h0;
    end else begin
      phase_d = phase_q + 2'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_d;
    end
  end
  assign bus.phase = phase_q;
  assign bus.div_clk = phase_q[1];
endmodule

/* verification/neighbour_ref_src.sv */
// Purpose: neighbouring converter driving our reference clock input
// Assumes: bench clock, changes on falling edges
// Notes: the line stands low while the source is stopped
module neighbour_ref_src (
  input wire logic ref_clk,
  input wire logic run,
  output logic ref_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q = 2'h0;
  initial ref_out = 1'b0;
  always @(negedge ref_clk) begin
    cnt_q <= run ? cnt_q + 2'h1 : 2'h0;
    ref_out <= run & cnt_q[1]; // quarter rate, as one branch of the tree
  end
endmodule

/* verification/converter_cal_mode_sync_ctrl_properties.sv */
// Purpose: port checks for trim sequencing, mode select and ref outputs
// Assumes: bound to the top module
// Notes: up_q keeps past-based checks away from reset release
module cal_sync_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic extended_control_enable_n,
  input wire logic dual_edge_select_pin,
  input wire logic extended_control_mode,
  input wire logic dual_edge_mode,
  input wire logic q_input_used,
  input wire logic sample_both_edges,
  input wire logic self_trim_active,
  input wire logic sync_ref_clock_out_a,
  input wire logic sync_ref_clock_out_b,
  input wire logic [1:0] divided_phase
);
  logic [10:0] run_q, run_d;
  logic [2:0] up_q, up_d;
  always_comb begin
    run_d = self_trim_active ? run_q + 11'h1 : 11'h0;
    up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  end
  always_ff @(posedge ref_clk) begin
    run_q <= rst ? 11'h0 : run_d;
    up_q <= rst ? 3'h0 : up_d;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_q_input_inverse: assert property (q_input_used == !dual_edge_mode)
    else $error("q input use wrong");
  a_both_edges_mode: assert property (sample_both_edges == dual_edge_mode)
    else $error("edge sampling wrong");
  a_ref_outs_equal: assert property (sync_ref_clock_out_a == sync_ref_clock_out_b)
    else $error("ref outputs differ");
  a_phase_steps: assert property (up_q == 3'h7 |->
    divided_phase == $past(divided_phase) + 2'h1 || divided_phase == 2'h0)
    else $error("divider phase jumped");
  a_ref_off_no_ecm: assert property ((!extended_control_mode) [*3] |->
    !sync_ref_clock_out_a) else $error("ref output on without enable");
  a_trim_run_len: assert property ($fell(self_trim_active) |-> run_q == 11'h400)
    else $error("trim run length wrong");
  a_trim_run_cap: assert property (self_trim_active |-> run_q < 11'h400)
    else $error("trim run too long");
  a_ecm_follows_pin: assert property (up_q == 3'h7 |->
    extended_control_mode == !$past(extended_control_enable_n, 3))
    else $error("extended control late");
  a_mode_from_pin: assert property ((up_q == 3'h7 && !extended_control_mode) [*4] |->
    dual_edge_mode == $past(dual_edge_select_pin, 3)) else $error("mode not from pin");
endmodule

/* verification/converter_cal_mode_sync_ctrl_tb.sv */
// Purpose: self-checking bench for trim, mode select and ref clocks
// Assumes: inputs change on falling edges
// Notes: windows allow for the pin synchronisers
module converter_cal_mode_sync_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic extended_control_enable_n = 1'b1;
  logic dual_edge_select_pin = 1'b0;
  logic power_on_trim_wait_select = 1'b0;
  logic trim_trigger_pin = 1'b0;
  logic sync_active = 1'b0;
  logic sync_slave = 1'b0;
  logic cfg_write = 1'b0;
  logic ref_run = 1'b0;
  logic [3:0] ref_in_delay = 4'h0;
  logic [3:0] cfg_addr = 4'h0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic ref_clk_in, extended_control_mode, dual_edge_mode, q_input_used, sample_both_edges;
  logic self_trim_active, sync_ref_clock_out_a, sync_ref_clock_out_b;
  logic [1:0] divided_phase;
  int n_fail = 0;
  int comparisons = 0;
  int n;
  converter_cal_mode_sync_ctrl converter_cal_mode_sync_ctrl_inst (.ref_clk, .rst,
    .extended_control_enable_n, .dual_edge_select_pin, .power_on_trim_wait_select,
    .trim_trigger_pin, .ref_clk_in, .sync_active, .sync_slave, .ref_in_delay, .cfg_write,
    .cfg_addr, .cfg_wdata, .extended_control_mode, .dual_edge_mode, .q_input_used,
    .sample_both_edges, .self_trim_active, .sync_ref_clock_out_a, .sync_ref_clock_out_b,
    .divided_phase);
  neighbour_ref_src neighbour_ref_src_inst (.ref_clk, .run(ref_run), .ref_out(ref_clk_in));
  initial forever #4 ref_clk = ~ref_clk;
  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string w, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %b seen %b", w, e, g);
    end
  endtask
  task automatic rng(input string w, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("FAIL %s expected %0d..%0d seen %0d", w, lo, hi, g);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
  endtask
  task automatic wait_trim(input logic lvl, input int lim);
    n = 0;
    while (self_trim_active !== lvl) begin
      @(negedge ref_clk);
      n++;
      if (n > lim) begin
        n_fail++;
        stop_test();
      end
    end
  endtask
  task automatic quiet(input int len);
    int h;
    h = 0;
    repeat (len) begin
      @(negedge ref_clk);
      if (self_trim_active !== 1'b0) h++;
    end
    rng("trim held off", 0, 0, h);
  endtask
  // host side: low then high times on the trigger pin
  task automatic pulse(input int lo, input int hi);
    trim_trigger_pin = 1'b0;
    repeat (lo) @(negedge ref_clk);
    trim_trigger_pin = 1'b1;
    repeat (hi) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    cfg_write = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge ref_clk);
    cfg_write = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic mode(input logic dem);
    repeat (5) @(negedge ref_clk);
    chk("dual_edge_mode", dem, dual_edge_mode);
    chk("q_input_used", !dem, q_input_used);
    chk("sample_both_edges", dem, sample_both_edges);
  endtask
  task automatic rises(input int lo);
    int r;
    int rb;
    logic p;
    logic pb;
    r = 0;
    rb = 0;
    p = sync_ref_clock_out_a;
    pb = sync_ref_clock_out_b;
    repeat (16) begin
      @(negedge ref_clk);
      if (sync_ref_clock_out_a === 1'b1 && p !== 1'b1) r++;
      if (sync_ref_clock_out_b === 1'b1 && pb !== 1'b1) rb++;
      p = sync_ref_clock_out_a;
      pb = sync_ref_clock_out_b;
    end
    rng("ref out rises in 16", lo, lo, r);
    rng("ref out b rises in 16", lo, lo, rb);
  endtask
  // divider phase seen when the incoming reference rises
  task automatic ref_phase(output logic [1:0] ph);
    logic p;
    p = ref_clk_in;
    ph = 2'h0;
    repeat (8) begin
      @(negedge ref_clk);
      if (ref_clk_in === 1'b1 && p !== 1'b1) ph = divided_phase;
      p = ref_clk_in;
    end
  endtask
  task automatic t_por(input logic long_wait, input int w);
    power_on_trim_wait_select = long_wait;
    do_reset();
    wait_trim(1'b1, w + 20);
    rng("power-on wait", w, w + 8, n);
    wait_trim(1'b0, 1100);
    rng("trim run", 1024, 1024, n);
  endtask
  task automatic t_held();
    power_on_trim_wait_select = 1'b0;
    trim_trigger_pin = 1'b1;
    do_reset();
    quiet(400);
    pulse(12, 5);
    trim_trigger_pin = 1'b0;
    quiet(40);
    pulse(12, 0);
    wait_trim(1'b1, 30);
    rng("trigger to trim", 10, 16, n);
    trim_trigger_pin = 1'b0;
    wait_trim(1'b0, 1100);
  endtask
  task automatic t_ecm();
    logic [1:0] ph_a;
    logic [1:0] ph_b;
    extended_control_enable_n = 1'b0;
    dual_edge_select_pin = 1'b1;
    mode(1'b0);
    chk("extended_control_mode", 1'b1, extended_control_mode);
    rises(0);
    wr(4'he, 16'h0002);
    rises(4);
    ref_run = 1'b1;
    sync_active = 1'b1;
    sync_slave = 1'b1;
    ref_in_delay = 4'h5;
    repeat (64) @(negedge ref_clk);
    ref_phase(ph_a);
    ref_in_delay = 4'h6;
    repeat (32) @(negedge ref_clk);
    ref_phase(ph_b);
    chk("phase moves with ref delay", 1'b1, ph_b == ph_a - 2'h1);
    wr(4'h0, 16'h0080);
    mode(1'b1);
    wr(4'h0, 16'h0081);
    wait_trim(1'b1, 30);
    rng("trim bit to trim", 6, 16, n);
    wr(4'h0, 16'h0080);
    wait_trim(1'b0, 1100);
    dual_edge_select_pin = 1'b0;
    extended_control_enable_n = 1'b1;
    mode(1'b0);
    wr(4'he, 16'h0002);
    rises(0);
  endtask
  initial begin
    t_por(1'b0, 256);
    t_por(1'b1, 4096);
    t_held();
    dual_edge_select_pin = 1'b1;
    mode(1'b1);
    dual_edge_select_pin = 1'b0;
    mode(1'b0);
    t_ecm();
    stop_test();
  end
endmodule
bind converter_cal_mode_sync_ctrl cal_sync_checker cal_sync_checker_inst (.ref_clk, .rst,
  .extended_control_enable_n, .dual_edge_select_pin, .extended_control_mode, .dual_edge_mode,
  .q_input_used, .sample_both_edges, .self_trim_active, .sync_ref_clock_out_a,
  .sync_ref_clock_out_b, .divided_phase);
